/* pkg/mmq_pkg.sv */
// Behaviour
// - interconnect marks first cycle of every transfer
// - marker generated when master lacks it
// - lane bus power-of-two wide, bit n byte n
// - lane selects only for multi-byte ports
// - writes update only enabled bytes
// - reads return whole word, lanes advisory
// - no lane input means all lanes set
// - pattern 1100 selects upper two bytes
// - mixed-width systems should use lane selects
// - deselected slave ignores every interface signal
// - select optional and discouraged
// - debug unlock permits writes to protected memory
// - byte address converted to slave word index
package mmq_pkg;
	localparam int MMQ_DATA_W     = 32;
	localparam int MMQ_LANES      = MMQ_DATA_W / 8;
	localparam int MMQ_ADDR_W     = 4;
	localparam int MMQ_WORDS      = 16;
	localparam int MMQ_BYTE_SHIFT = 2;
	localparam int MMQ_ROM_BASE   = 8;
	localparam logic [MMQ_DATA_W-1:0] MMQ_RST_DATA = 32'h0000_0000;
	localparam logic [MMQ_LANES-1:0]  MMQ_ALL_LANES = 4'hf;

	typedef enum logic [1:0] {MMQ_IDLE, MMQ_WAIT, MMQ_DONE} mmq_state_t;

	// legal lane pattern: single lane, or power-of-two aligned group
	function automatic logic mmq_lanes_legal(input logic [MMQ_LANES-1:0] be);
		logic ok;
		ok = 1'b0;
		case (be)
			4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction
endpackage

/* pkg/mmq_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mmq_if
	import mmq_pkg::*;
	(
	input wire logic clk_sys
);
	logic [MMQ_ADDR_W-1:0] address;
	logic                  read;
	logic                  write;
	logic [MMQ_DATA_W-1:0] writedata;
	logic [MMQ_DATA_W-1:0] readdata;
	logic                  readdatavalid;
	logic                  waitrequest;
	logic                  begintransfer;
	logic [MMQ_LANES-1:0]  lane_sel;
	logic                  chip_sel;
	logic                  debug_unlock;

	modport fabric (output address, read, write, writedata, begintransfer, lane_sel,
		chip_sel, debug_unlock, input readdata, readdatavalid, waitrequest);
	modport slave (input address, read, write, writedata, begintransfer, lane_sel,
		chip_sel, debug_unlock, output readdata, readdatavalid, waitrequest);
endinterface
`default_nettype wire

/* hdl/mmq_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module mmq_slave
	import mmq_pkg::*;
	#(
	parameter bit HAS_LANES = 1'b1,
	parameter bit HAS_SEL   = 1'b1
	)
	(
	// clock, reset, enable
	input  wire logic      clk_sys,
	input  wire logic      rst,
	input  wire logic      ce,
	// link
	mmq_if.slave           bus,
	// user side
	output logic           rom_write_refused,
	output logic [MMQ_DATA_W-1:0] first_word
);
	logic [MMQ_DATA_W-1:0] rdata_r;
	logic                  rvalid_r;
	logic                  refused_r;

	////////////////////////////////////////////////////////////////////////////
	wire                  sel_ok   = HAS_SEL ? bus.chip_sel : 1'b1;
	wire [MMQ_LANES-1:0]  lanes    = HAS_LANES ? bus.lane_sel : MMQ_ALL_LANES;
	wire                  is_rom   = (bus.address >= MMQ_ADDR_W'(MMQ_ROM_BASE));
	wire                  wr_go    = sel_ok && bus.write;
	wire                  wr_allow = wr_go && (!is_rom || bus.debug_unlock);
	wire                  rd_go    = sel_ok && bus.read;
	wire [MMQ_DATA_W-1:0] cur;
	wire [MMQ_DATA_W-1:0] word0;

	assign bus.waitrequest   = 1'b0;
	assign bus.readdata      = rdata_r;
	assign bus.readdatavalid = rvalid_r;
	assign rom_write_refused = refused_r;
	assign first_word        = word0;

	////////////////////////////////////////////////////////////////////////////
	// one byte array per lane, so each lane has a single writing process
	genvar g;
	generate
		for (g = 0; g < MMQ_LANES; g++)
		begin : g_lane
			logic [7:0] byte_r [MMQ_WORDS];
			wire        lane_wr = ce && wr_allow && lanes[g];

			assign cur[8*g +: 8]   = byte_r[bus.address];
			assign word0[8*g +: 8] = byte_r[0];

			always_ff @(posedge clk_sys)
			begin
				if (rst)
				begin
					for (int w = 0; w < MMQ_WORDS; w++)
						byte_r[w] <= MMQ_RST_DATA[8*g +: 8];
				end
				else if (lane_wr)
					byte_r[bus.address] <= bus.writedata[8*g +: 8];
			end
		end
	endgenerate

	// reads have no side effect, so whole word returned
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rdata_r   <= MMQ_RST_DATA;
			rvalid_r  <= 1'b0;
			refused_r <= 1'b0;
		end
		else if (ce)
		begin
			rvalid_r  <= rd_go;
			rdata_r   <= rd_go ? cur : rdata_r;
			refused_r <= wr_go && !wr_allow;
		end
	end
endmodule
`default_nettype wire

/* hdl/mmq_fabric.sv */
`timescale 1ns/1ps
`default_nettype none
module mmq_fabric
	import mmq_pkg::*;
	(
	// clock, reset, enable
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic                  ce,
	// user request
	input  wire logic                  req_valid,
	input  wire logic                  req_write,
	input  wire logic [MMQ_ADDR_W+MMQ_BYTE_SHIFT-1:0] req_byte_addr,
	input  wire logic [MMQ_DATA_W-1:0] req_wdata,
	input  wire logic [MMQ_LANES-1:0]  req_lanes,
	input  wire logic                  req_debug,
	output logic                       req_ready,
	output logic                       req_bad_lanes,
	// user answer
	output logic                       rsp_valid,
	output logic [MMQ_DATA_W-1:0]      rsp_data,
	// link
	mmq_if.fabric                      bus
);
	mmq_state_t            state_r, state_nxt;
	logic [MMQ_ADDR_W-1:0] addr_r;
	logic [MMQ_DATA_W-1:0] wdata_r, rsp_r;
	logic [MMQ_LANES-1:0]  lanes_r;
	logic                  wr_r, dbg_r, first_r, rv_r;

	////////////////////////////////////////////////////////////////////////////
	wire legal = mmq_lanes_legal(req_lanes);
	wire take  = ce && req_valid && legal && (state_r == MMQ_IDLE);

	assign req_ready     = (state_r == MMQ_IDLE);
	assign req_bad_lanes = req_valid && !legal;
	assign bus.address       = addr_r;
	assign bus.writedata     = wdata_r;
	assign bus.lane_sel      = lanes_r;
	assign bus.read          = (state_r == MMQ_WAIT) && !wr_r;
	assign bus.write         = (state_r == MMQ_WAIT) && wr_r;
	assign bus.chip_sel      = (state_r == MMQ_WAIT);
	assign bus.begintransfer = first_r;
	assign bus.debug_unlock  = (state_r == MMQ_WAIT) && dbg_r;
	assign rsp_valid = rv_r;
	assign rsp_data  = rsp_r;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			MMQ_IDLE: if (take) state_nxt = MMQ_WAIT;
			MMQ_WAIT: if (ce && !bus.waitrequest) state_nxt = wr_r ? MMQ_IDLE : MMQ_DONE;
			MMQ_DONE: if (ce && bus.readdatavalid) state_nxt = MMQ_IDLE;
			default:  state_nxt = MMQ_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_r <= MMQ_IDLE;
			addr_r  <= '0;
			wdata_r <= MMQ_RST_DATA;
			lanes_r <= '0;
			wr_r    <= 1'b0;
			dbg_r   <= 1'b0;
			first_r <= 1'b0;
			rv_r    <= 1'b0;
			rsp_r   <= MMQ_RST_DATA;
		end
		else if (ce)
		begin
			state_r <= state_nxt;
			first_r <= take;
			rv_r    <= (state_r == MMQ_DONE) && bus.readdatavalid;
			if (state_r == MMQ_DONE && bus.readdatavalid)
				rsp_r <= bus.readdata;
			if (take)
			begin
				addr_r  <= req_byte_addr[MMQ_BYTE_SHIFT +: MMQ_ADDR_W];
				wdata_r <= req_wdata;
				lanes_r <= req_lanes;
				wr_r    <= req_write;
				dbg_r   <= req_debug;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/mmq_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mmq_properties
	import mmq_pkg::*;
	(
	// clock, reset
	input wire logic                 clk_sys,
	input wire logic                 rst,
	// link
	input wire logic                 read,
	input wire logic                 write,
	input wire logic                 begintransfer,
	input wire logic                 chip_sel,
	input wire logic [MMQ_LANES-1:0] lane_sel,
	input wire logic                 readdatavalid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_mark_first: assert property ($rose(read | write) |-> begintransfer)
		else $error("mark missing");
	a_mark_req: assert property (begintransfer |-> (read | write) && chip_sel)
		else $error("mark alone");
	a_sel_req: assert property (chip_sel |-> read | write)
		else $error("select alone");
	a_one_cycle: assert property (read | write |=> !(read | write))
		else $error("strobe held");
	a_lane_legal: assert property (write |-> lane_sel inside {1, 2, 4, 8, 3, 12, 15})
		else $error("bad lanes");
	a_read_ans: assert property (chip_sel && read |=> readdatavalid ##1 !readdatavalid)
		else $error("read answer");
	a_valid_cause: assert property (readdatavalid |-> $past(chip_sel && read))
		else $error("stray valid");
	a_reset_idle: assert property (disable iff (1'b0) rst |=> !(read | write | chip_sel))
		else $error("busy in reset");
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
	import mmq_pkg::*;
	;
	logic        clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_debug = 1'b0;
	logic [5:0]  req_byte_addr = 6'h00;
	logic [31:0] req_wdata = 32'h0, rsp_data, first_word, r, mem [16];
	logic [3:0]  req_lanes = 4'hf;
	logic        ce = 1'b1;
	logic        req_ready, req_bad_lanes, rsp_valid, refused;
	int          err_count = 0, cmp_count = 0, refusals = 0, want_ref = 0;
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (refused === 1'b1) refusals++;
	mmq_if bus (.clk_sys);
	mmq_slave i_mmq_slave (.clk_sys, .rst, .ce, .bus(bus.slave),
		.rom_write_refused(refused), .first_word);
	mmq_fabric i_mmq_fabric (.clk_sys, .rst, .ce, .req_valid, .req_write, .req_byte_addr,
		.req_wdata, .req_lanes, .req_debug, .req_ready, .req_bad_lanes, .rsp_valid, .rsp_data,
		.bus(bus.fabric));
	mmq_properties i_mmq_properties (.clk_sys, .rst, .read(bus.read), .write(bus.write),
		.begintransfer(bus.begintransfer), .chip_sel(bus.chip_sel), .lane_sel(bus.lane_sel),
		.readdatavalid(bus.readdatavalid));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic want_legal(input logic [3:0] l);
		return l inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
	endfunction
	// e low freezes both ends for the whole call, so nothing is taken
	task automatic op(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] l, input logic g, input logic e);
		logic lg;
		logic ok;
		int   pulses;
		lg = want_legal(l);
		ok = lg && e;
		pulses = 0;
		ce <= e;
		req_valid <= 1'b1;
		req_write <= w;
		req_byte_addr <= {a, 2'h0};
		req_wdata <= d;
		req_lanes <= l;
		req_debug <= g;
		#1 chk({31'h0, req_bad_lanes}, {31'h0, !lg});
		@(posedge clk_sys);
		req_valid <= 1'b0;
		@(posedge clk_sys);
		chk({31'h0, req_ready}, {31'h0, !ok});
		repeat (3)
		begin
			@(posedge clk_sys);
			if (rsp_valid === 1'b1)
				pulses++;
		end
		chk(pulses, (ok && !w) ? 1 : 0);
		for (int n = 0; n < 4; n++)
			if (ok && w && l[n] && (a < 8 || g))
				mem[a][8*n +: 8] = d[8*n +: 8];
		if (ok && w && a >= 8 && !g)
			want_ref++;
		if (ok && !w)
			chk(rsp_data, mem[a]);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#20000;
		err_count++;
		end_of_test;
	end
	initial
	begin
		r = $urandom(60);
		foreach (mem[i]) mem[i] = MMQ_RST_DATA;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		op(1'b1, 4'h3, 32'h4433_2211, 4'hc, 1'b0, 1'b1);
		op(1'b0, 4'h3, 32'h0, 4'h1, 1'b0, 1'b1);
		op(1'b1, 4'h9, 32'hdead_beef, 4'hf, 1'b0, 1'b1);
		op(1'b1, 4'ha, 32'h1234_5678, 4'h3, 1'b1, 1'b1);
		op(1'b1, 4'h2, 32'hffff_ffff, 4'h5, 1'b0, 1'b1);
		op(1'b1, 4'h3, 32'hffff_ffff, 4'hf, 1'b0, 1'b0);
		op(1'b0, 4'h3, 32'h0, 4'hf, 1'b0, 1'b1);
		$display("corner test done");
		repeat (60)
		begin
			r = $urandom();
			op(r[0], r[4:1], $urandom(), r[8:5], r[9], r[11:10] != 2'h0);
		end
		for (int i = 0; i < 16; i++) op(1'b0, i[3:0], 32'h0, 4'hf, 1'b0, 1'b1);
		chk(first_word, mem[0]);
		chk(refusals, want_ref);
		$display("random test done");
		end_of_test;
	end
endmodule
`default_nettype wire
